// file: hw/tmrb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmrb_top #(
  parameter int unsigned FAST_PERIOD = tmrb_pkg::FAST_PERIOD_CYC,
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h10 // arbitrary value
) (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // byte port from the bus engine
  input wire logic wr_valid_in,
  input wire logic wr_first_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_req_in,
  input wire logic ara_read_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic alert_pending_out,
  // converter
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire tmrb_pkg::tmrb_meas_t conv_result_in,
  // pins
  input wire logic standby_pin_n_in,
  output logic alert_n_out
);
  typedef enum logic [0:0] {CV_IDLE, CV_BUSY} tmrb_conv_state_t;

  tmrb_conv_state_t conv_state;
  logic [7:0] pointer;
  logic [7:0] loc_temp;
  logic [7:0] rem_temp;
  logic [7:0] loc_hi;
  logic [7:0] loc_lo;
  logic [7:0] rem_hi;
  logic [7:0] rem_lo;
  logic [7:0] rem_offset;
  logic [1:0] cfg;
  logic [2:0] rate_code;
  logic [4:0] alert_flags;
  logic [4:0] next_flags;
  logic [4:0] flag_cause;
  logic [31:0] period_cnt;
  logic pin_meta;
  logic pin_sync;
  logic remote_open;
  logic run_is_shot;
  logic oneshot_pend;
  logic cmp_pulse;
  logic alert_latch;
  logic standby;
  logic timer_hit;
  logic data_wr;
  logic status_rd;
  logic store;

  // rate code to period in cycles
  function automatic logic [31:0] rate_period(input logic [2:0] code);
    rate_period = FAST_PERIOD << (tmrb_pkg::MAX_CODE - code);
  endfunction : rate_period

  // read mux over the read pointer values
  function automatic logic [7:0] read_mux(input logic [7:0] ptr);
    case (ptr)
      tmrb_pkg::RD_LOC_TEMP: read_mux = loc_temp;
      tmrb_pkg::RD_REM_TEMP: read_mux = rem_temp;
      tmrb_pkg::RD_STATUS: read_mux = {conv_state == CV_BUSY, alert_flags, 2'h0};
      tmrb_pkg::RD_CONFIG: read_mux = {cfg, 6'h00};
      tmrb_pkg::RD_RATE: read_mux = {5'h00, rate_code};
      tmrb_pkg::RD_LOC_HI: read_mux = loc_hi;
      tmrb_pkg::RD_LOC_LO: read_mux = loc_lo;
      tmrb_pkg::RD_REM_HI: read_mux = rem_hi;
      tmrb_pkg::RD_REM_LO: read_mux = rem_lo;
      tmrb_pkg::RD_OFFSET: read_mux = rem_offset;
      tmrb_pkg::RD_MAKER: read_mux = MAKER_ID;
      tmrb_pkg::RD_REVISION: read_mux = REVISION_ID;
      default: read_mux = tmrb_pkg::BAD_READ;
    endcase
  endfunction : read_mux

  // access strobes, standby and timer hit
  assign data_wr = wr_valid_in && !wr_first_in;
  assign status_rd = rd_req_in && (pointer == tmrb_pkg::RD_STATUS);
  assign standby = cfg[0] || !pin_sync;
  assign timer_hit = period_cnt >= rate_period(rate_code) - 32'h1;
  // a standby result is kept only if a one-shot asked for it
  assign store = (conv_state == CV_BUSY) && conv_done_in && (run_is_shot || !standby);

  // standby pin synchroniser
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (ce_in) begin
      pin_meta <= standby_pin_n_in;
      pin_sync <= pin_meta;
    end
  end

  // pointer loads from the first write byte
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pointer <= 8'h00;
    end else if (ce_in && wr_valid_in && wr_first_in) begin
      pointer <= wr_data_in;
    end
  end

  // writable registers, decoded on write pointer values only
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg <= tmrb_pkg::CFG_RST;
      rate_code <= tmrb_pkg::RATE_RST;
      loc_hi <= tmrb_pkg::HIGH_RST;
      loc_lo <= tmrb_pkg::LOW_RST;
      rem_hi <= tmrb_pkg::HIGH_RST;
      rem_lo <= tmrb_pkg::LOW_RST;
      rem_offset <= tmrb_pkg::OFFSET_RST;
    end else if (ce_in && data_wr) begin
      case (pointer)
        tmrb_pkg::WR_CONFIG: cfg <= wr_data_in[tmrb_pkg::CFG_BLOCK_BIT -: 2];
        tmrb_pkg::WR_RATE: rate_code <= wr_data_in[2:0]; // upper bits dropped
        tmrb_pkg::WR_LOC_HI: loc_hi <= wr_data_in;
        tmrb_pkg::WR_LOC_LO: loc_lo <= wr_data_in;
        tmrb_pkg::WR_REM_HI: rem_hi <= wr_data_in;
        tmrb_pkg::WR_REM_LO: rem_lo <= wr_data_in;
        tmrb_pkg::WR_OFFSET: rem_offset <= wr_data_in;
        default: ;
      endcase
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else if (ce_in) begin
      rd_valid_out <= rd_req_in;
      if (rd_req_in) begin
        rd_data_out <= read_mux(pointer);
      end
    end
  end

  // one-shot request; a new write wins over the consuming start
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      oneshot_pend <= 1'b0;
    end else if (ce_in) begin
      if (data_wr && pointer == tmrb_pkg::WR_ONE_SHOT) begin
        oneshot_pend <= 1'b1;
      end else if (conv_state == CV_IDLE) begin
        oneshot_pend <= 1'b0;
      end
    end
  end

  // conversion period timer, parked in standby
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      period_cnt <= 32'h0;
    end else if (ce_in) begin
      if (standby || conv_start_out || conv_state == CV_BUSY) begin
        period_cnt <= 32'h0;
      end else if (!timer_hit) begin
        period_cnt <= period_cnt + 32'h1;
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      conv_state <= CV_IDLE;
      conv_start_out <= 1'b0;
      run_is_shot <= 1'b0;
    end else if (ce_in) begin
      conv_start_out <= 1'b0;
      case (conv_state)
        CV_IDLE: begin
          if (oneshot_pend || (!standby && timer_hit)) begin
            conv_state <= CV_BUSY;
            conv_start_out <= 1'b1;
            run_is_shot <= oneshot_pend;
          end
        end
        CV_BUSY: begin
          if (conv_done_in) begin
            conv_state <= CV_IDLE;
          end
        end
        default: conv_state <= CV_IDLE;
      endcase
    end
  end

  // measurement store; compare runs once after reset too
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      loc_temp <= tmrb_pkg::TEMP_RST;
      rem_temp <= tmrb_pkg::TEMP_RST;
      remote_open <= 1'b0;
      cmp_pulse <= 1'b1;
    end else if (ce_in) begin
      cmp_pulse <= store;
      if (store) begin
        loc_temp <= conv_result_in.loc;
        rem_temp <= conv_result_in.rem + rem_offset;
        remote_open <= conv_result_in.open;
      end
    end
  end

  // signed limit causes
  assign flag_cause[tmrb_pkg::FLAG_LOC_OVER] = $signed(loc_temp) > $signed(loc_hi);
  assign flag_cause[tmrb_pkg::FLAG_LOC_UNDER] = $signed(loc_temp) < $signed(loc_lo);
  assign flag_cause[tmrb_pkg::FLAG_REM_OVER] = $signed(rem_temp) > $signed(rem_hi);
  assign flag_cause[tmrb_pkg::FLAG_REM_UNDER] = $signed(rem_temp) < $signed(rem_lo);
  assign flag_cause[tmrb_pkg::FLAG_OPEN] = remote_open;

  // sticky flags: set beats the read clear
  always_comb begin
    next_flags = alert_flags;
    if (status_rd) begin
      next_flags = alert_flags & flag_cause;
    end
    if (cmp_pulse) begin
      next_flags = next_flags | flag_cause;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      alert_flags <= tmrb_pkg::FLAGS_RST;
    end else if (ce_in) begin
      alert_flags <= next_flags;
    end
  end

  // alarm latch; status reads leave it alone
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      alert_latch <= 1'b0;
    end else if (ce_in) begin
      if (|alert_flags) begin
        alert_latch <= 1'b1;
      end else if (ara_read_in && !(|flag_cause)) begin
        alert_latch <= 1'b0;
      end
    end
  end

  // pin drive; masking also hides a latch already set
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      alert_n_out <= 1'b1;
      alert_pending_out <= 1'b0;
    end else if (ce_in) begin
      alert_n_out <= !(alert_latch && !cfg[1]);
      alert_pending_out <= alert_latch;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_shot_wr;
    ce_in && data_wr && pointer == tmrb_pkg::WR_ONE_SHOT && conv_state == CV_IDLE && !oneshot_pend && !timer_hit;
  endsequence
  sequence s_flag_up;
    ce_in && (|alert_flags);
  endsequence

  a_pointer_load: assert property (ce_in && wr_valid_in && wr_first_in |=> pointer == $past(wr_data_in))
    else $error("pointer not loaded from first byte");
  a_values_conv_only: assert property (ce_in && !store |=> $stable(loc_temp) && $stable(rem_temp))
    else $error("measurement changed without a store");
  a_busy_on_start: assert property (conv_start_out |-> conv_state == CV_BUSY)
    else $error("start without busy state");
  a_flag_sets_latch: assert property (s_flag_up |=> alert_latch)
    else $error("flag did not set alarm latch");
  a_flag_sticky: assert property (ce_in && !status_rd |=> (alert_flags & $past(alert_flags)) == $past(alert_flags))
    else $error("flag dropped without status read");
  a_flag_cause_held: assert property (ce_in && status_rd |=> (alert_flags & $past(flag_cause)) == $past(flag_cause & alert_flags))
    else $error("flag with live cause was cleared");
  a_latch_hold: assert property (ce_in && alert_latch && !ara_read_in |=> alert_latch)
    else $error("alarm latch cleared without alert read");
  a_mask_blocks: assert property (ce_in && cfg[1] |=> alert_n_out)
    else $error("masked alarm drove pin low");
  a_standby_hold: assert property (ce_in && standby && conv_state == CV_IDLE && !oneshot_pend |=> $stable(rem_temp))
    else $error("measurement moved in standby");
  a_offset_add: assert property (ce_in && store |=> rem_temp == 8'($past(conv_result_in.rem) + $past(rem_offset)))
    else $error("remote offset not added");
  a_shot_starts: assert property (s_shot_wr ##1 ce_in |=> conv_start_out)
    else $error("one-shot did not start a conversion");
endmodule : tmrb_top
`default_nettype wire

// file: pkg/tmrb_pkg.sv
// Function
// - each register decodes at distinct read and write pointer values, except the offset, which reads and writes at 0x11
// - first byte of every write loads the pointer register
// - measurement registers are loaded by the converter only, read-only on bus
// - status bit 7 reads one while a conversion runs
// - status flags sit at bits 6 to 2, bits 1 and 0 reserved
// - any set flag sets the alarm latch and pulls the alarm low
// - status read clears only flags whose cause has gone
// - flags stay set until status read or reset
// - alarm latch clears on alert-address read, only when all is clear
// - config bit 6 selects run (0) or standby (1)
// - standby pin low forces standby regardless of config
// - measurements hold their values during standby
// - config bit 7 masks the alarm output
// - rate code divides conversions: period is fastest times 2^(7-code)
// - high limit trips on greater, low limit on less, strictly
// - limits compare as signed values, negative allowed
// - signed offset is added to every remote measurement
// - write to one-shot address starts one conversion, data dropped
// - measurements reset to 0x80, high limits 0x7F, low limits 0xC9
// - one-shot in standby converts once then stays in standby
// - results are 8-bit two's complement, one count per degree
package tmrb_pkg;
  // read pointer values
  localparam logic [7:0] RD_LOC_TEMP = 8'h00;
  localparam logic [7:0] RD_REM_TEMP = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CONFIG = 8'h03;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] RD_LOC_HI = 8'h05;
  localparam logic [7:0] RD_LOC_LO = 8'h06;
  localparam logic [7:0] RD_REM_HI = 8'h07;
  localparam logic [7:0] RD_REM_LO = 8'h08;
  localparam logic [7:0] RD_OFFSET = 8'h11;
  localparam logic [7:0] RD_MAKER = 8'hFE;
  localparam logic [7:0] RD_REVISION = 8'hFF;
  // write pointer values
  localparam logic [7:0] WR_CONFIG = 8'h09;
  localparam logic [7:0] WR_RATE = 8'h0A;
  localparam logic [7:0] WR_LOC_HI = 8'h0B;
  localparam logic [7:0] WR_LOC_LO = 8'h0C;
  localparam logic [7:0] WR_REM_HI = 8'h0D;
  localparam logic [7:0] WR_REM_LO = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT = 8'h0F;
  localparam logic [7:0] WR_OFFSET = 8'h11;
  // field positions
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_FLAG_LSB = 2;
  localparam int FLAG_LOC_OVER = 4;
  localparam int FLAG_LOC_UNDER = 3;
  localparam int FLAG_REM_OVER = 2;
  localparam int FLAG_REM_UNDER = 1;
  localparam int FLAG_OPEN = 0;
  localparam int CFG_BLOCK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  // reset values
  localparam logic [7:0] TEMP_RST = 8'h80;
  localparam logic [7:0] HIGH_RST = 8'h7F;
  localparam logic [7:0] LOW_RST = 8'hC9;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [2:0] RATE_RST = 3'h2;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] BAD_READ = 8'hFF;
  localparam logic [2:0] MAX_CODE = 3'h7;
  // timing: fastest conversion period
  localparam int CLK_HZ = 20_000_000;
  localparam int FAST_PERIOD_MS = 125;
  localparam int FAST_PERIOD_CYC = CLK_HZ / 1000 * FAST_PERIOD_MS;
  // one converter result
  typedef struct packed {
    logic open;
    logic [7:0] rem;
    logic [7:0] loc;
  } tmrb_meas_t;
endpackage : tmrb_pkg

// file: tb/tmrb_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmrb_conv_model #(
  parameter int unsigned DELAY = 30
) (
  // clock
  input wire logic clock_in,
  // converter handshake
  input wire logic start_in,
  output logic done_out,
  // value to report
  input wire tmrb_pkg::tmrb_meas_t value_in,
  output tmrb_pkg::tmrb_meas_t result_out
);
  int unsigned remain = 0;
  // one result per start; the bus shows garbage outside done so stale data is never trusted
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    result_out <= ~value_in;
    if (start_in) begin
      remain <= DELAY;
    end else if (remain != 0) begin
      remain <= remain - 1;
      if (remain == 1) begin
        done_out <= 1'b1;
        result_out <= value_in;
      end
    end
  end
endmodule : tmrb_conv_model
`default_nettype wire

// file: tb/tmrb_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tmrb_tb_top;
  localparam logic [7:0] MAKER = 8'hA7; // arbitrary value
  localparam logic [7:0] REV = 8'h6B; // arbitrary value
  logic clock_in, rst_in, wr_valid_in, wr_first_in, rd_req_in, ara_read_in, standby_pin_n_in;
  logic [7:0] wr_data_in, rd_data_out;
  logic rd_valid_out, alert_pending_out, conv_start_out, conv_done_in, alert_n_out;
  tmrb_pkg::tmrb_meas_t conv_result_in, meas;
  int failures = 0, check_count = 0, start_cnt = 0, cyc = 0, t_last = 0, t_prev = 0, d7;
  // last entry is a reserved read address, so no write-only address is ever read
  logic [7:0] ra [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h10};
  logic [7:0] re [11] = '{8'h80, 8'h80, 8'h28, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9, 8'h00, 8'hFF};
  // short base period keeps rate tests to a few hundred cycles
  tmrb_top #(.FAST_PERIOD(20), .MAKER_ID(MAKER), .REVISION_ID(REV)) i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1), .wr_valid_in(wr_valid_in),
    .wr_first_in(wr_first_in), .wr_data_in(wr_data_in), .rd_req_in(rd_req_in),
    .ara_read_in(ara_read_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .alert_pending_out(alert_pending_out), .conv_start_out(conv_start_out),
    .conv_done_in(conv_done_in), .conv_result_in(conv_result_in),
    .standby_pin_n_in(standby_pin_n_in), .alert_n_out(alert_n_out));
  tmrb_conv_model #(.DELAY(30)) i_conv (.clock_in(clock_in), .start_in(conv_start_out),
    .done_out(conv_done_in), .value_in(meas), .result_out(conv_result_in));
  // 20 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // start pulses and the spacing of the last two
  always @(posedge clock_in) begin
    cyc++;
    if (conv_start_out === 1'b1) begin
      start_cnt++;
      t_prev = t_last;
      t_last = cyc;
    end
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wr_byte(input logic first, input logic [7:0] d);
    @(negedge clock_in);
    wr_valid_in = 1'b1;
    wr_first_in = first;
    wr_data_in = d;
    @(negedge clock_in);
    wr_valid_in = 1'b0;
  endtask : wr_byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_byte(1'b1, a);
    wr_byte(1'b0, d);
  endtask : wr
  // point at a read address first, then read and compare under a mask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    wr_byte(1'b1, a);
    @(negedge clock_in);
    rd_req_in = 1'b1;
    @(negedge clock_in);
    rd_req_in = 1'b0;
    `CHK(rd_valid_out, 1'b1)
    `CHK(rd_data_out & m, e)
  endtask : rd_chk
  task automatic ara();
    @(negedge clock_in);
    ara_read_in = 1'b1;
    @(negedge clock_in);
    ara_read_in = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask : ara
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clock_in);
    failures++;
    end_of_test();
  end
  // main sequence; powered up in standby so nothing converts on its own
  initial begin
    rst_in = 1'b1;
    {wr_valid_in, wr_first_in, rd_req_in, ara_read_in, standby_pin_n_in} = '0;
    wr_data_in = 8'h00;
    meas = {1'b0, 8'h12, 8'h51};
    repeat (16) @(negedge clock_in);
    rst_in = 1'b0;
    for (int i = 0; i < 11; i++) rd_chk(ra[i], re[i]);
    rd_chk(8'hFE, MAKER);
    rd_chk(8'hFF, REV);
    `CHK({alert_n_out, alert_pending_out}, 2'b01)
    wr(8'h0C, 8'h80);
    wr(8'h0E, 8'h80);
    rd_chk(8'h02, 8'h28);
    rd_chk(8'h02, 8'h00);
    `CHK(alert_n_out, 1'b0)
    ara();
    `CHK({alert_n_out, alert_pending_out}, 2'b10)
    // one-shot while in standby, with a negative offset
    wr(8'h11, 8'hFC);
    wr(8'h0B, 8'h50);
    wr(8'h0F, 8'hA5);
    rd_chk(8'h02, 8'h80);
    repeat (40) @(negedge clock_in);
    rd_chk(8'h00, 8'h51);
    rd_chk(8'h01, 8'h0E);
    rd_chk(8'h02, 8'h40);
    rd_chk(8'h02, 8'h40);
    repeat (100) @(negedge clock_in);
    `CHK(start_cnt, 1)
    `CHK(alert_n_out, 1'b0)
    wr(8'h09, 8'hC0);
    repeat (3) @(negedge clock_in);
    `CHK({alert_n_out, alert_pending_out}, 2'b11)
    rd_chk(8'h03, 8'hC0);
    // config standby alone holds the converter
    wr(8'h0A, 8'h07);
    standby_pin_n_in = 1'b1;
    meas = {1'b0, 8'h30, 8'h20};
    repeat (100) @(negedge clock_in);
    `CHK(start_cnt, 1)
    wr(8'h09, 8'h00);
    repeat (3) @(negedge clock_in);
    `CHK(alert_n_out, 1'b0)
    repeat (200) @(negedge clock_in);
    d7 = t_last - t_prev;
    wr(8'h0A, 8'h06);
    repeat (300) @(negedge clock_in);
    `CHK(t_last - t_prev - d7, 20)
    rd_chk(8'h00, 8'h20);
    rd_chk(8'h01, 8'h2C);
    rd_chk(8'h02, 8'h40, 8'h7C);
    rd_chk(8'h02, 8'h00, 8'h7C);
    ara();
    `CHK(alert_n_out, 1'b1)
    // pin standby overrides a running config
    standby_pin_n_in = 1'b0;
    repeat (100) @(negedge clock_in);
    d7 = start_cnt;
    meas = {1'b0, 8'h40, 8'h11};
    repeat (200) @(negedge clock_in);
    `CHK(start_cnt, d7)
    rd_chk(8'h00, 8'h20);
    end_of_test();
  end
endmodule : tmrb_tb_top
`default_nettype wire
